// ### pkg/wic_pkg.sv
// package for the window column and exposure configuration block
// assumes one 10 MHz clock and a two-wire serial configuration port
`default_nettype none
package wic_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_COL_START_LO = 8'h4a;
  localparam logic [7:0] REG_WIDTH_HI = 8'h4b;
  localparam logic [7:0] REG_WIDTH_LO = 8'h4c;
  localparam logic [7:0] REG_EXP_HI = 8'h4e;
  localparam logic [7:0] REG_EXP_LO = 8'h4f;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_COL_START_LO = 8'h08;
  localparam logic [2:0] RST_WIDTH_HI = 3'h4;
  localparam logic [7:0] RST_WIDTH_LO = 8'h00;
  localparam logic [5:0] RST_EXP_HI = 6'h04;
  localparam logic [7:0] RST_EXP_LO = 8'hff;
  localparam logic RST_UPD = 1'b0;
  localparam logic RST_FACTORY = 1'b0;
  localparam int FACTORY_POS = 7;
  localparam int UPD_POS = 6;
  localparam logic [4:0] WIDTH_HI_PAD = 5'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // serial port constants
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h2a; // arbitrary value
  localparam int PIN_W = 2;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam logic [PIN_W-1:0] PIN_IDLE = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
  } wic_serial_st_t;

  typedef struct packed {
    logic [PIN_W-1:0] ff1;
    logic [PIN_W-1:0] ff2;
    logic [PIN_W-1:0] ff3;
    logic [PIN_W-1:0] q;
  } wic_sync_t;

  typedef struct packed {
    logic [10:0] start_col;
    logic [10:0] width;
  } wic_window_t;

  typedef struct packed {
    logic [13:0] rows;
    logic [14:0] row_times;
    logic [28:0] clocks;
    logic pending;
  } wic_exposure_t;

  typedef struct packed {
    wic_serial_st_t st;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic mack;
    logic sda_drv;
    logic [7:0] col_lo;
    logic [2:0] wid_hi;
    logic [7:0] wid_lo;
    logic factory;
    logic upd;
    logic [5:0] exp_hi_sh;
    logic [7:0] exp_lo_sh;
    logic [13:0] active;
    logic pending;
    logic [28:0] exp_clocks;
    logic [13:0] h_blank;
    logic [13:0] v_blank;
  } wic_state_t;

endpackage : wic_pkg

`default_nettype wire

// ### verilog/wic_pin_sync.sv
// three-stage synchroniser for the serial port pins
// assumes the pins are asynchronous to clk_in and idle high
`timescale 1ns/1ns
`default_nettype none

module wic_pin_sync (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [wic_pkg::PIN_W-1:0] pins_in,
  output logic [wic_pkg::PIN_W-1:0] pins_out
);
  import wic_pkg::*;

  wic_sync_t s;
  wic_sync_t next_s;

  // ----------------------------------------------------------------
  // sync chain
  // ----------------------------------------------------------------
  // ff1 feeds only ff2; a change is taken once ff2 and ff3 agree
  always_comb begin
    next_s = s;
    next_s.ff1 = pins_in;
    next_s.ff2 = s.ff1;
    next_s.ff3 = s.ff2;
    for (int i = 0; i < PIN_W; i++) begin
      if (s.ff2[i] == s.ff3[i]) begin
        next_s.q[i] = s.ff3[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s <= '{ff1: PIN_IDLE, ff2: PIN_IDLE, ff3: PIN_IDLE, q: PIN_IDLE};
    end else begin
      s <= next_s;
    end
  end

  assign pins_out = s.q;

endmodule : wic_pin_sync

`default_nettype wire

// ### verilog/wic_cfg.sv
// window column and exposure configuration registers behind a serial port
// assumes frame_start_in comes from the sensor timing on clk_in
`timescale 1ns/1ns
`default_nettype none

module wic_cfg #(
  parameter logic [6:0] DEV_ADDR = wic_pkg::DEFAULT_DEV_ADDR
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic frame_start_in,
  input wire logic [2:0] col_start_high_in,
  input wire logic [13:0] virt_cols_in,
  input wire logic [13:0] virt_rows_in,
  input wire logic [13:0] win_rows_in,
  input wire logic [13:0] virt_row_clocks_in,
  output wic_pkg::wic_window_t window_out,
  output wic_pkg::wic_exposure_t exposure_out,
  output logic factory_reserved_bit_out,
  output logic [13:0] h_blank_out,
  output logic [13:0] v_blank_out
);
  import wic_pkg::*;

  wic_state_t s;
  wic_state_t next_s;
  logic [PIN_W-1:0] pins;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic wr_en;
  logic [7:0] wr_data;
  logic [10:0] width;

  wic_pin_sync u_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .pins_in({sda_in, scl_in}),
    .pins_out(pins)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_byte(input wic_state_t st, input logic [7:0] addr);
    logic [7:0] d;
    d = READ_UNMAPPED;
    unique case (addr)
      REG_COL_START_LO: d = st.col_lo;
      REG_WIDTH_HI: d = {WIDTH_HI_PAD, st.wid_hi};
      REG_WIDTH_LO: d = st.wid_lo;
      REG_EXP_HI: d = {st.factory, st.upd, st.exp_hi_sh};
      REG_EXP_LO: d = st.exp_lo_sh;
      default: d = READ_UNMAPPED;
    endcase
    return d;
  endfunction : read_byte

  assign scl = pins[PIN_SCL];
  assign sda = pins[PIN_SDA];
  assign scl_rise = scl & ~s.scl_q;
  assign scl_fall = ~scl & s.scl_q;
  assign start_cond = scl & s.scl_q & s.sda_q & ~sda;
  assign stop_cond = scl & s.scl_q & ~s.sda_q & sda;
  assign wr_en = scl_fall && (s.st == ST_WDATA) && (s.bit_cnt == BYTE_BITS);
  assign wr_data = s.shreg;
  assign width = {s.wid_hi, s.wid_lo};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.scl_q = scl;
    next_s.sda_q = sda;
    if (start_cond) begin
      next_s.st = ST_ADDR;
      next_s.bit_cnt = '0;
      next_s.sda_drv = 1'b0;
    end else if (stop_cond) begin
      next_s.st = ST_IDLE;
      next_s.sda_drv = 1'b0;
    end else begin
      unique case (s.st)
        ST_IDLE: begin
          next_s.sda_drv = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            next_s.shreg = {s.shreg[6:0], sda};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end else if (scl_fall && s.bit_cnt == BYTE_BITS) begin
            next_s.sda_drv = 1'b1;
            if (s.st == ST_ADDR) begin
              // other addresses leave the bus alone until the next start
              if (s.shreg[7:1] == DEV_ADDR) begin
                next_s.rw = s.shreg[0];
                next_s.st = ST_ADDR_ACK;
              end else begin
                next_s.sda_drv = 1'b0;
                next_s.st = ST_IDLE;
              end
            end else if (s.st == ST_PTR) begin
              next_s.ptr = s.shreg;
              next_s.st = ST_PTR_ACK;
            end else begin
              next_s.ptr = s.ptr + 8'h01;
              next_s.st = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            next_s.bit_cnt = '0;
            if (s.rw) begin
              next_s.shreg = read_byte(s, s.ptr);
              next_s.sda_drv = ~next_s.shreg[7];
              next_s.ptr = s.ptr + 8'h01;
              next_s.st = ST_RDATA;
            end else begin
              next_s.sda_drv = 1'b0;
              next_s.st = ST_PTR;
            end
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            next_s.bit_cnt = '0;
            next_s.sda_drv = 1'b0;
            next_s.st = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (s.bit_cnt == BYTE_BITS) begin
              next_s.sda_drv = 1'b0;
              next_s.st = ST_RACK;
            end else begin
              next_s.shreg = {s.shreg[6:0], 1'b0};
              next_s.sda_drv = ~s.shreg[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            next_s.mack = ~sda;
          end else if (scl_fall) begin
            // a master nack ends the read burst
            if (s.mack) begin
              next_s.bit_cnt = '0;
              next_s.shreg = read_byte(s, s.ptr);
              next_s.sda_drv = ~next_s.shreg[7];
              next_s.ptr = s.ptr + 8'h01;
              next_s.st = ST_RDATA;
            end else begin
              next_s.st = ST_IDLE;
            end
          end
        end
      endcase
    end

    // frame boundary first so a same-cycle toggle write stays pending
    if (frame_start_in && s.pending) begin
      next_s.active = {s.exp_hi_sh, s.exp_lo_sh};
      next_s.pending = 1'b0;
    end

    if (wr_en) begin
      unique case (s.ptr)
        REG_COL_START_LO: next_s.col_lo = wr_data;
        REG_WIDTH_HI: next_s.wid_hi = wr_data[2:0];
        REG_WIDTH_LO: next_s.wid_lo = wr_data;
        REG_EXP_HI: begin
          next_s.factory = wr_data[FACTORY_POS];
          next_s.upd = wr_data[UPD_POS];
          next_s.exp_hi_sh = wr_data[5:0];
          if (wr_data[UPD_POS] != s.upd) begin
            next_s.pending = 1'b1;
          end
        end
        REG_EXP_LO: next_s.exp_lo_sh = wr_data;
        default: next_s.pending = next_s.pending;
      endcase
    end

    // duration depends only on active value and virtual row time
    next_s.exp_clocks = 29'({1'b0, s.active} + 15'h0001) *
      29'(virt_row_clocks_in);
    // no size check: an undersized virtual frame simply wraps
    next_s.h_blank = virt_cols_in - {3'h0, width};
    next_s.v_blank = virt_rows_in - win_rows_in;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.col_lo <= RST_COL_START_LO;
      s.wid_hi <= RST_WIDTH_HI;
      s.wid_lo <= RST_WIDTH_LO;
      s.factory <= RST_FACTORY;
      s.upd <= RST_UPD;
      s.exp_hi_sh <= RST_EXP_HI;
      s.exp_lo_sh <= RST_EXP_LO;
      s.active <= {RST_EXP_HI, RST_EXP_LO};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain: only ever pulls low; window may point past the array
  assign sda_out = 1'b0;
  assign sda_oe_out = s.sda_drv;
  assign window_out = '{start_col: {col_start_high_in, s.col_lo}, width: width};
  assign exposure_out = '{rows: s.active,
    row_times: {1'b0, s.active} + 15'h0001,
    clocks: s.exp_clocks,
    pending: s.pending};
  assign factory_reserved_bit_out = s.factory;
  assign h_blank_out = s.h_blank;
  assign v_blank_out = s.v_blank;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence toggle_wr;
    wr_en && s.ptr == REG_EXP_HI && wr_data[UPD_POS] != s.upd;
  endsequence

  sequence same_wr;
    wr_en && s.ptr == REG_EXP_HI && wr_data[UPD_POS] == s.upd;
  endsequence

  sequence apply_pt;
    frame_start_in && s.pending && !wr_en;
  endsequence

  chk_exp_only_frame: assert property (
    !$stable(s.active) |-> $past(frame_start_in) && $past(s.pending))
    else $error("active exposure changed outside a frame boundary");

  chk_toggle_pends: assert property (toggle_wr |=> s.pending)
    else $error("toggled update did not set pending");

  chk_same_upd: assert property (
    same_wr and !s.pending |=> !s.pending && $stable(s.active))
    else $error("unchanged update bit altered exposure");

  chk_apply_next: assert property (
    apply_pt |=> !s.pending && s.active[13:8] == $past(s.exp_hi_sh)
      && s.active[7:0] == $past(s.exp_lo_sh))
    else $error("pending exposure not applied at frame start");

  chk_shadow_hold: assert property (
    wr_en && s.ptr == REG_EXP_LO && !s.pending |=> $stable(s.active) ##1 $stable(s.active))
    else $error("low byte write reached active exposure");

  chk_col_write: assert property (
    wr_en && s.ptr == REG_COL_START_LO |=> window_out.start_col[7:0] == $past(wr_data))
    else $error("start column write lost");

  chk_width_write: assert property (
    wr_en && s.ptr == REG_WIDTH_HI |=> window_out.width[10:8] == $past(wr_data[2:0]))
    else $error("width high write lost");

  chk_width_low: assert property (
    wr_en && s.ptr == REG_WIDTH_LO |=> window_out.width[7:0] == $past(wr_data))
    else $error("width low write lost");

  // first edge after release still shows the reset zeros, so skip it
  chk_exp_clocks: assert property (
    $past(rstn_in) |-> exposure_out.clocks ==
      29'($past(exposure_out.row_times)) * 29'($past(virt_row_clocks_in)))
    else $error("exposure clock count wrong");

  chk_blanking: assert property (
    $past(rstn_in) |-> h_blank_out == $past(virt_cols_in) - {3'h0, $past(window_out.width)})
    else $error("horizontal blanking wrong");

endmodule : wic_cfg

`default_nettype wire

// ### verif/wic_host.sv
// serial host model that programs the configuration registers
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ns
`default_nettype none

module wic_host #(
  parameter logic [6:0] DEV_ADDR = wic_pkg::DEFAULT_DEV_ADDR
) (
  input wire logic clk_in,
  input wire logic sda_line_in,
  output logic scl_out,
  output logic sda_low_out
);
  import wic_pkg::*;
  // ----
  // bit level
  // ----
  // phases kept well above the design's five-clock minimum
  localparam int PH = 8;
  logic g;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic bitx(input logic b, output logic r);
    sda_low_out <= !b;
    repeat (PH) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (PH) @(posedge clk_in);
    r = sda_line_in;
    scl_out <= 1'b0;
    repeat (PH) @(posedge clk_in);
  endtask : bitx
  // also serves as repeated start, since it releases data first
  task automatic start();
    sda_low_out <= 1'b0;
    repeat (PH) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (PH) @(posedge clk_in);
    sda_low_out <= 1'b1;
    repeat (PH) @(posedge clk_in);
    scl_out <= 1'b0;
    repeat (PH) @(posedge clk_in);
  endtask : start
  task automatic stop();
    sda_low_out <= 1'b1;
    repeat (PH) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (PH) @(posedge clk_in);
    sda_low_out <= 1'b0;
    repeat (PH) @(posedge clk_in);
  endtask : stop
  task automatic tx(input logic [7:0] v, inout logic ok);
    for (int i = 7; i >= 0; i--) bitx(v[i], g);
    bitx(1'b1, g);
    ok = ok & !g;
  endtask : tx
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    tx({DEV_ADDR, 1'b0}, ok);
    tx(p, ok);
    tx(d, ok);
    stop();
  endtask : wr
  // two-byte burst: master ack after the first byte, nack after the second
  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic [7:0] d2,
    output logic ok);
    ok = 1'b1;
    start();
    tx({DEV_ADDR, 1'b0}, ok);
    tx(p, ok);
    start();
    tx({DEV_ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(1'b0, g);
    for (int i = 7; i >= 0; i--) bitx(1'b1, d2[i]);
    bitx(1'b1, g);
    stop();
  endtask : rd
  // address phase only, to see whether anyone acknowledges
  task automatic probe(input logic [6:0] a, output logic ok);
    ok = 1'b1;
    start();
    tx({a, 1'b0}, ok);
    stop();
  endtask : probe
endmodule : wic_host
`default_nettype wire

// ### verif/wic_cfg_tb_top.sv
// self-checking bench for the window column and exposure registers
// assumes the host model and the design package are compiled first
`timescale 1ns/1ns
`default_nettype none

module wic_cfg_tb_top;
  import wic_pkg::*;
  logic clk_in, rstn_in, scl, sda_low, sda_line, sda_out, sda_oe_out, fs, fac, ok;
  logic [2:0] col_hi;
  logic [13:0] vcols, vrows, wrows, vclk, hb, vb, v;
  logic [7:0] rdat, rdat2;
  logic [31:0] seed;
  wic_window_t win;
  wic_exposure_t expo;
  int n_mismatch, samples_checked;
  int m_col, m_wid, m_hi, m_lo, m_upd, m_fac, m_rows, m_pend;
  // pull-up on the data wire
  assign sda_line = !(sda_low | (sda_oe_out & !sda_out));
  wic_host i_wic_host (.clk_in(clk_in), .sda_line_in(sda_line), .scl_out(scl),
    .sda_low_out(sda_low));
  wic_cfg i_wic_cfg (.clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .frame_start_in(fs),
    .col_start_high_in(col_hi), .virt_cols_in(vcols), .virt_rows_in(vrows),
    .win_rows_in(wrows), .virt_row_clocks_in(vclk), .window_out(win), .exposure_out(expo),
    .factory_reserved_bit_out(fac), .h_blank_out(hb), .v_blank_out(vb));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // ----
  // helpers
  // ----
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    i_wic_host.wr(p, d, ok);
    chk("write ack", 1, ok);
    case (p)
      REG_COL_START_LO: m_col = d;
      REG_WIDTH_HI: m_wid = d[2:0] * 256 + m_wid % 256;
      REG_WIDTH_LO: m_wid = m_wid / 256 * 256 + d;
      REG_EXP_LO: m_lo = d;
      REG_EXP_HI: begin
        if (d[6] != m_upd[0]) m_pend = 1;
        m_upd = d[6];
        m_fac = d[7];
        m_hi = d[5:0];
      end
      default: ;
    endcase
  endtask : wreg
  function automatic int mreg(input logic [7:0] p);
    case (p)
      REG_COL_START_LO: return m_col;
      REG_WIDTH_HI: return m_wid / 256;
      REG_WIDTH_LO: return m_wid % 256;
      REG_EXP_HI: return m_fac * 128 + m_upd * 64 + m_hi;
      REG_EXP_LO: return m_lo;
      default: return 0;
    endcase
  endfunction : mreg
  task automatic rdall();
    for (logic [7:0] a = 8'h4a; a <= 8'h4f; a++) begin
      i_wic_host.rd(a, rdat, rdat2, ok);
      chk("read ack", 1, ok);
      chk("read data", mreg(a), rdat);
      chk("read next", mreg(a + 8'h01), rdat2);
    end
  endtask : rdall
  task automatic setin(input logic under);
    logic [13:0] w;
    w = 14'(rnd() % 1024);
    @(posedge clk_in);
    col_hi <= 3'(rnd() % 5);
    vclk <= 14'(rnd());
    wrows <= w;
    vrows <= w + 14'(1 + rnd() % 64);
    vcols <= under ? 14'(m_wid - 3) : 14'(m_wid + 6 + rnd() % 64);
    repeat (3) @(posedge clk_in);
  endtask : setin
  task automatic frame();
    @(posedge clk_in);
    fs <= 1'b1;
    @(posedge clk_in);
    fs <= 1'b0;
    if (m_pend != 0) m_rows = m_hi * 256 + m_lo;
    m_pend = 0;
    repeat (3) @(posedge clk_in);
  endtask : frame
  task automatic outs();
    @(negedge clk_in);
    chk("start col", {col_hi, m_col[7:0]}, win.start_col);
    chk("width", m_wid, win.width);
    chk("rows", m_rows, expo.rows);
    chk("row times", m_rows + 1, expo.row_times);
    chk("clocks", (m_rows + 1) * vclk, expo.clocks);
    chk("pending", m_pend, expo.pending);
    chk("factory", m_fac, fac);
    chk("h blank", (vcols - m_wid) & 14'h3fff, hb);
    chk("v blank", (vrows - wrows) & 14'h3fff, vb);
  endtask : outs
  // ----
  // sequence
  // ----
  initial begin
    seed = 32'he3f7;
    n_mismatch = 0;
    samples_checked = 0;
    rstn_in = 1'b0;
    fs = 1'b0;
    col_hi = 3'h0;
    vcols = 14'h0;
    vrows = 14'h0;
    wrows = 14'h0;
    vclk = 14'h0;
    m_col = 8;
    m_wid = 1024;
    m_hi = 4;
    m_lo = 255;
    m_upd = 0;
    m_fac = 0;
    m_rows = 1279;
    m_pend = 0;
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    setin(1'b0);
    outs();
    rdall();
    // a foreign address must get no acknowledge
    i_wic_host.probe(~DEFAULT_DEV_ADDR, ok);
    chk("foreign ack", 0, ok);
    for (int k = 0; k < 3; k++) begin
      wreg(REG_COL_START_LO, 8'(rnd()));
      wreg(REG_WIDTH_HI, 8'(rnd()));
      wreg(REG_WIDTH_LO, 8'(rnd()));
      wreg(8'h4d, 8'(rnd()));
      setin(k == 1);
      outs();
    end
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 14'h3fff : (k == 1) ? 14'h0 : 14'(rnd());
      wreg(REG_EXP_LO, v[7:0]);
      wreg(REG_EXP_HI, {1'(k == 0), m_upd[0], v[13:8]});
      frame();
      outs();
      wreg(REG_EXP_HI, {1'(k == 0), !m_upd[0], v[13:8]});
      wreg(REG_WIDTH_LO, 8'(rnd()));
      setin(1'b0);
      outs();
      frame();
      outs();
    end
    rdall();
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk_in);
    n_mismatch++;
    $display("MISMATCH run length expected below limit seen limit reached");
    give_verdict();
  end
endmodule : wic_cfg_tb_top
`default_nettype wire
